/* rtl/pwm_channel.sv */
`timescale 1ns/100ps
`default_nettype none
module pwm_channel
  import pwm_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              start,
  input  wire logic              stop,
  input  wire logic              clear,
  input  wire logic              coarse,
  input  wire logic [FREQ_W-1:0] freq,
  input  wire logic [DUTY_W-1:0] duty,
  output logic                   pwm,
  output logic                   active
);

  chan_state_t state;
  logic [31:0] step;
  logic [31:0] phase;
  logic [31:0] thresh;
  logic [32:0] sum;
  logic        wrap;

  assign sum    = {1'b0, phase} + {1'b0, step};
  assign wrap   = sum >= {1'b0, PHASE_MOD};
  assign active = (state == CH_RUN);

  // Run state; stop and clear win over start
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state <= CH_IDLE;
    else
    begin
      case (state)
        CH_IDLE:
          if (start && !stop && !clear)
            state <= CH_RUN;
        CH_RUN:
          if (stop || clear)
            state <= CH_IDLE;
        default:
          state <= CH_IDLE;
      endcase
    end
  end

  // Phase step fixed at start: tenths of Hz or whole Hz
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      step <= '0;
    else if (start)
      step <= coarse ? 32'(freq) * COARSE_MULT : 32'(freq);
  end

  // Phase accumulator, one wrap per output period
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      phase <= '0;
    else if (start)
      phase <= '0;
    else if (active)
      phase <= wrap ? 32'(sum - {1'b0, PHASE_MOD}) : sum[31:0];
  end

  // Duty threshold taken at start and at each period boundary
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      thresh <= '0;
    else if (start || (active && wrap))
      thresh <= 32'(duty) * DUTY_UNIT;
  end

  // Zero threshold never high, full threshold always high
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pwm <= 1'b0;
    else
      pwm <= active && (phase < thresh);
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  duty_zero_low_a: assert property (active && thresh == '0 |=> !pwm)
    else $error("pwm high at zero duty");
  duty_full_high_a: assert property (active && thresh == PHASE_MOD |=> pwm)
    else $error("pwm low at full duty");
  stop_ends_run_a: assert property (stop |=> !active ##1 !pwm)
    else $error("channel kept running after stop");
  idle_output_low_a: assert property (!active && !$past(active) |-> !pwm)
    else $error("pwm high while idle");

endmodule
`default_nettype wire

/* rtl/pwm_pkg.sv */
package pwm_pkg;

  // Clock rate and phase scaling
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam logic [31:0] PHASE_MOD   = 32'(64'(CLK_HZ) * 64'h0A);
  localparam logic [15:0] DUTY_FULL   = 16'h03E8;
  localparam logic [31:0] DUTY_UNIT   = PHASE_MOD / 32'h0000_03E8;
  localparam logic [15:0] COARSE_MAX  = 16'h8020;
  localparam logic [31:0] COARSE_MULT = 32'h0000_000A;

  // Channel count and operand widths
  localparam int NUM_CH = 4;
  localparam int FREQ_W = 16;
  localparam int DUTY_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFF_CMD      = 8'h00;
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_FREQ0    = 8'h10;
  localparam logic [7:0] OFF_DUTY0    = 8'h20;
  localparam logic [7:0] OFF_ACT_LO   = 8'h30;
  localparam logic [7:0] OFF_ACT_HI   = 8'h34;
  localparam logic [7:0] OFF_ORG      = 8'h38;
  localparam logic [7:0] OFF_IRQ_ST   = 8'h40;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h44;
  localparam logic [7:0] OFF_OUT0     = 8'h48;
  localparam logic [7:0] OFF_OUT1     = 8'h4C;

  // Field positions
  localparam int CMD_STOP_LSB  = 4;
  localparam int ACT_BIT_A     = 0;
  localparam int ACT_BIT_B     = 8;
  localparam int TERM_BIT_A    = 4;
  localparam int TERM_BIT_B    = 5;
  localparam int ORG_MODE_LSB  = 0;
  localparam int IRQ_ORG       = 0;
  localparam int IRQ_OPERAND   = 1;
  localparam int IRQ_START_LSB = 2;
  localparam int IRQ_W         = 6;

  // Origin search operation modes
  typedef enum logic [1:0] {
    ORG_MODE0 = 2'b00,
    ORG_MODE1 = 2'b01,
    ORG_MODE2 = 2'b10,
    ORG_MODE3 = 2'b11
  } org_mode_t;

  // Channel states
  typedef enum logic {
    CH_IDLE = 1'b0,
    CH_RUN  = 1'b1
  } chan_state_t;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* rtl/sync2.sv */
`timescale 1ns/100ps
`default_nettype none
module sync2
  import pwm_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // Two-stage synchroniser; first stage read only by the second
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

/* rtl/variable_duty_pulse_outputs.sv */
`timescale 1ns/100ps
`default_nettype none
module variable_duty_pulse_outputs
  import pwm_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              run_mode,
  output logic [15:0]            out_word0,
  output logic [15:0]            out_word1,
  output logic                   irq
);

  logic              aw_held;
  logic              w_held;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              do_write;
  logic [NUM_CH-1:0] coarse_mode;
  logic [FREQ_W-1:0] freq_q [NUM_CH];
  logic [DUTY_W-1:0] duty_q [NUM_CH];
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  irq_mask;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;
  logic [15:0]       norm0;
  logic [15:0]       norm1;
  logic [NUM_CH-1:0] start_req;
  logic [NUM_CH-1:0] stop_req;
  logic [NUM_CH-1:0] start_ok;
  logic [NUM_CH-1:0] operand_ok;
  logic [NUM_CH-1:0] duty_wr;
  logic [NUM_CH-1:0] duty_wr_bad;
  logic [NUM_CH-1:0] ch_pwm;
  logic [NUM_CH-1:0] ch_active;
  logic [15:0]       act_lo;
  logic [15:0]       act_hi;
  logic [15:0]       new_duty;
  logic              org_err;
  logic              run_s;
  logic              run_d;
  logic              run_edge;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic [15:0]       next_out0;
  logic [15:0]       next_out1;

  // Byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0])
      r[7:0] = d[7:0];
    if (s[1])
      r[15:8] = d[15:8];
    return r;
  endfunction

  // Write channel acceptance, address and data in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= 8'(s_axi_awaddr);
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  // Write response, error for unmapped offsets
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == OFF_CMD || aw_addr == OFF_MODE || aw_addr == OFF_ORG
          || aw_addr == OFF_IRQ_ST || aw_addr == OFF_IRQ_MASK || aw_addr == OFF_OUT0
          || aw_addr == OFF_OUT1 || aw_addr[7:4] == OFF_FREQ0[7:4]
          || aw_addr[7:4] == OFF_DUTY0[7:4] || aw_addr == OFF_ACT_LO
          || aw_addr == OFF_ACT_HI)
        s_axi_bresp <= (aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      else
        s_axi_bresp <= RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Command strobes from a write to the command word
  assign start_req = (do_write && aw_addr == OFF_CMD && w_strb[0])
                     ? w_data[NUM_CH-1:0] : '0;
  assign stop_req  = (do_write && aw_addr == OFF_CMD && w_strb[0])
                     ? w_data[CMD_STOP_LSB +: NUM_CH] : '0;
  assign new_duty  = merge16('0, w_data, w_strb);

  // Origin search request in mode 1 or 2; channels 0..3 each share a pulse terminal bit of output word 0 or 1
  assign org_err = do_write && aw_addr == OFF_ORG && w_strb[0]
                   && (org_mode_t'(w_data[ORG_MODE_LSB +: 2]) == ORG_MODE1
                    || org_mode_t'(w_data[ORG_MODE_LSB +: 2]) == ORG_MODE2);

  // Controller run level from its pin; either edge clears all channels
  sync2 #(.W(1)) run_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (run_mode),
    .sync_out (run_s)
  );

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      run_d <= 1'b0;
    else
      run_d <= run_s;
  end

  assign run_edge = run_s ^ run_d;

  // Per-channel operand checks, operand registers and generators
  generate
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
      assign operand_ok[c]  = freq_q[c] != '0
                              && (!coarse_mode[c] || freq_q[c] <= COARSE_MAX)
                              && duty_q[c] <= DUTY_FULL;
      assign start_ok[c]    = start_req[c] && operand_ok[c];
      assign duty_wr[c]     = do_write && aw_addr == (OFF_DUTY0 + 8'(4 * c));
      assign duty_wr_bad[c] = duty_wr[c] && new_duty > DUTY_FULL;

      // Frequency word per channel
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          freq_q[c] <= '0;
        else if (do_write && aw_addr == (OFF_FREQ0 + 8'(4 * c)))
          freq_q[c] <= merge16(freq_q[c], w_data, w_strb);
      end

      // Duty word, live to a running channel; out-of-range writes dropped
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          duty_q[c] <= '0;
        else if (duty_wr[c] && !duty_wr_bad[c])
          duty_q[c] <= new_duty;
      end

      pwm_channel u_ch (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .start  (start_ok[c]),
        .stop   (stop_req[c]),
        .clear  (run_edge),
        .coarse (coarse_mode[c]),
        .freq   (freq_q[c]),
        .duty   (duty_q[c]),
        .pwm    (ch_pwm[c]),
        .active (ch_active[c])
      );
    end
  endgenerate

  // Frequency range select per channel
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      coarse_mode <= '0;
    else if (do_write && aw_addr == OFF_MODE && w_strb[0])
      coarse_mode <= w_data[NUM_CH-1:0];
  end

  // Normal output words
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      norm0 <= '0;
      norm1 <= '0;
    end
    else if (do_write && aw_addr == OFF_OUT0)
      norm0 <= merge16(norm0, w_data, w_strb);
    else if (do_write && aw_addr == OFF_OUT1)
      norm1 <= merge16(norm1, w_data, w_strb);
  end

  // Interrupt events: set wins over a write-one clear
  assign irq_set = {start_ok, |(start_req & ~operand_ok) | (|duty_wr_bad), org_err};
  assign irq_clr = (do_write && aw_addr == OFF_IRQ_ST && w_strb[0])
                   ? w_data[IRQ_W-1:0] : '0;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_status <= '0;
    else
      irq_status <= (irq_status & ~irq_clr) | irq_set;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask <= '0;
    else if (do_write && aw_addr == OFF_IRQ_MASK && w_strb[0])
      irq_mask <= w_data[IRQ_W-1:0];
  end

  assign irq = |(irq_status & irq_mask);

  // In-progress flags follow channel state directly
  always_comb
  begin
    act_lo             = '0;
    act_hi             = '0;
    act_lo[ACT_BIT_A]  = ch_active[0];
    act_lo[ACT_BIT_B]  = ch_active[1];
    act_hi[ACT_BIT_A]  = ch_active[2];
    act_hi[ACT_BIT_B]  = ch_active[3];
  end

  // Read decode
  always_comb
  begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    if (s_axi_araddr[1:0] != 2'h0)
      next_rresp = RESP_SLVERR;
    else if (8'(s_axi_araddr) == OFF_CMD)
      next_rdata = '0;
    else if (8'(s_axi_araddr) == OFF_MODE)
      next_rdata = 32'(coarse_mode);
    else if (s_axi_araddr[7:4] == OFF_FREQ0[7:4])
      next_rdata = 32'(freq_q[s_axi_araddr[3:2]]);
    else if (s_axi_araddr[7:4] == OFF_DUTY0[7:4])
      next_rdata = 32'(duty_q[s_axi_araddr[3:2]]);
    else if (8'(s_axi_araddr) == OFF_ACT_LO)
      next_rdata = 32'(act_lo);
    else if (8'(s_axi_araddr) == OFF_ACT_HI)
      next_rdata = 32'(act_hi);
    else if (8'(s_axi_araddr) == OFF_ORG)
      next_rdata = '0;
    else if (8'(s_axi_araddr) == OFF_IRQ_ST)
      next_rdata = 32'(irq_status);
    else if (8'(s_axi_araddr) == OFF_IRQ_MASK)
      next_rdata = 32'(irq_mask);
    else if (8'(s_axi_araddr) == OFF_OUT0)
      next_rdata = 32'(norm0);
    else if (8'(s_axi_araddr) == OFF_OUT1)
      next_rdata = 32'(norm1);
    else
      next_rresp = RESP_SLVERR;
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Terminal muxing: a running channel owns its bit
  always_comb
  begin
    next_out0             = norm0;
    next_out1             = norm1;
    if (ch_active[0])
      next_out0[TERM_BIT_A] = ch_pwm[0];
    if (ch_active[1])
      next_out0[TERM_BIT_B] = ch_pwm[1];
    if (ch_active[2])
      next_out1[TERM_BIT_A] = ch_pwm[2];
    if (ch_active[3])
      next_out1[TERM_BIT_B] = ch_pwm[3];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_word0 <= '0;
      out_word1 <= '0;
    end
    else
    begin
      out_word0 <= next_out0;
      out_word1 <= next_out1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  org_error_flag_a: assert property (org_err |=> irq_status[IRQ_ORG])
    else $error("origin search error not flagged");
  run_edge_clear_a: assert property (run_edge |=> ch_active == '0)
    else $error("flags not cleared on run change");
  valid_start_a: assert property (start_ok[0] && !stop_req[0] && !run_edge |=> ch_active[0])
    else $error("channel 0 did not start");
  terminal_route_a: assert property (ch_active[1] |=> out_word0[TERM_BIT_B] == $past(ch_pwm[1]))
    else $error("channel 1 not on its terminal");
  flag_map_a: assert property (s_axi_arvalid && s_axi_arready
    && 8'(s_axi_araddr) == OFF_ACT_HI |=> s_axi_rdata[ACT_BIT_B] == $past(ch_active[3]))
    else $error("in-progress flag mapping wrong");
  bad_duty_kept_a: assert property (duty_wr_bad[0] |=> duty_q[0] == $past(duty_q[0]))
    else $error("out of range duty stored");

  stop_run_c: cover property (ch_active[2] && stop_req[2] ##1 !ch_active[2]);
  duty_change_c: cover property (ch_active[0] && duty_wr[0] && !duty_wr_bad[0]);
  org_reject_c: cover property (org_err ##1 irq);

endmodule
`default_nettype wire

/* sim/ctl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ctl_model
  import pwm_pkg::*;
(
  input  wire logic        mclk,
  output var  logic [7:0]  awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [7:0]  araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  // Bus idle at time zero
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // Write cycle; released payload shows inverted value
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge mclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awvalid && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // Read cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arvalid && arready === 1'b1)
      begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
    end while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Start command: frequency in tenths of Hz or whole Hz, duty in tenths, then start bit
  task automatic start_ch(input int c, input logic [15:0] f, input logic [15:0] d);
    logic [1:0] r;
    wr(8'(OFF_FREQ0 + 4 * c), {16'h0000, f}, r);
    wr(8'(OFF_DUTY0 + 4 * c), {16'h0000, d}, r);
    wr(OFF_CMD, 32'(1 << c), r);
  endtask
endmodule
`default_nettype wire

/* sim/variable_duty_pulse_outputs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; $display("unexpected at %0t: got %0h want %0h", $time, (a), (b)); end end
module variable_duty_pulse_outputs_tb
  import pwm_pkg::*;
;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] rs;} row_t;
  localparam int WIN = 19055;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        run_mode = 1'b0;
  wire  [7:0]  awaddr, araddr;
  wire  [31:0] wdata, rdata;
  wire  [3:0]  wstrb;
  wire  [1:0]  bresp, rresp;
  wire         awvalid, awready, wvalid, wready, bvalid, bready;
  wire         arvalid, arready, rvalid, rready;
  wire  [15:0] out_word0, out_word1;
  wire         irq;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          hi, rises;
  logic [31:0] rd;
  logic [1:0]  rs;
  row_t rows [11] = '{
    '{OFF_OUT0, 32'h0000_FFFF, 32'h0000_FFFF, RESP_OKAY},
    '{OFF_OUT1, 32'h0000_00A5, 32'h0000_00A5, RESP_OKAY},
    '{OFF_MODE, 32'h0000_000F, 32'h0000_000F, RESP_OKAY},
    '{OFF_IRQ_MASK, 32'h0000_003F, 32'h0000_003F, RESP_OKAY},
    '{OFF_FREQ0, 32'h0000_1234, 32'h0000_1234, RESP_OKAY},
    '{OFF_DUTY0, 32'h0000_03E8, 32'h0000_03E8, RESP_OKAY},
    '{OFF_DUTY0, 32'h0000_03E9, 32'h0000_03E8, RESP_OKAY},
    '{OFF_CMD, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
    '{OFF_ACT_LO, 32'h0000_FFFF, 32'h0000_0000, RESP_OKAY},
    '{8'h80, 32'h0000_FFFF, 32'h0000_0000, RESP_SLVERR},
    '{8'h02, 32'h0000_FFFF, 32'h0000_0000, RESP_SLVERR}};

  // Clock
  always #4 mclk = ~mclk;

  variable_duty_pulse_outputs dut_u (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .run_mode(run_mode),
    .out_word0(out_word0), .out_word1(out_word1), .irq(irq));

  ctl_model ctl_u (.mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    ctl_u.wr(a, d, r);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    ctl_u.rd(a, rd, rs);
    `CHK(rd, e)
  endtask

  // High cycles and rising edges of one terminal bit
  task automatic meas(input int n, input bit w, input int b);
    logic v, p;
    hi = 0;
    rises = 0;
    p = 1'b1;
    repeat (n)
    begin
      @(posedge mclk);
      v = w ? out_word1[b] : out_word0[b];
      if (v !== 1'b0 && v !== 1'b1)
        `CHK(v, 1'b0)
      hi += (v === 1'b1);
      rises += (v === 1'b1 && p === 1'b0);
      p = v;
    end
  endtask

  function automatic bit near(int v, int e, int tol);
    return (v >= e - tol) && (v <= e + tol);
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (80000) @(posedge mclk);
    error_cnt++;
    close_out();
  end

  // Main sequence
  initial
  begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      ctl_u.wr(rows[i].a, rows[i].w, rs);
      `CHK(rs, rows[i].rs)
      ctl_u.rd(rows[i].a, rd, rs);
      `CHK(rd, rows[i].r)
      `CHK(rs, rows[i].rs)
    end
    $display("test register table done");
    rchk(OFF_IRQ_ST, 32'h0000_0002);
    `CHK(irq, 1'b1)
    wreg(OFF_IRQ_ST, 32'h0000_003F);
    `CHK(irq, 1'b0)
    wreg(OFF_IRQ_MASK, 32'h0000_0002);
    for (int m = 0; m < 4; m++)
    begin
      wreg(OFF_ORG, 32'(m));
      rchk(OFF_IRQ_ST, 32'(m == 1 || m == 2));
      `CHK(irq, 1'b0)
      wreg(OFF_IRQ_ST, 32'h0000_003F);
    end
    $display("test origin modes done");
    wreg(OFF_MODE, 32'h0000_0001);
    ctl_u.start_ch(0, COARSE_MAX + 16'h0001, 16'h0190);
    rchk(OFF_ACT_LO, 32'h0000_0000);
    `CHK(irq, 1'b1)
    wreg(OFF_IRQ_ST, 32'h0000_003F);
    wreg(OFF_MODE, 32'h0000_0000);
    ctl_u.start_ch(0, 16'h0000, 16'h0190);
    rchk(OFF_ACT_LO, 32'h0000_0000);
    wreg(OFF_IRQ_ST, 32'h0000_003F);
    $display("test operand errors done");
    wreg(OFF_MODE, 32'h0000_0001);
    ctl_u.start_ch(0, COARSE_MAX, 16'h0190);
    rchk(OFF_ACT_LO, 32'h0000_0001);
    rchk(OFF_IRQ_ST, 32'h0000_0004);
    repeat (8) @(posedge mclk);
    meas(WIN, 1'b0, 4);
    `CHK(near(hi, WIN * 400 / 1000, 40), 1'b1)
    `CHK(near(rises, 5, 1), 1'b1)
    wreg(OFF_DUTY0, 32'h0000_0320);
    repeat (4000) @(posedge mclk);
    meas(WIN, 1'b0, 4);
    `CHK(near(hi, WIN * 800 / 1000, 40), 1'b1)
    rchk(OFF_ACT_LO, 32'h0000_0001);
    wreg(OFF_DUTY0, 32'h0000_0000);
    repeat (4000) @(posedge mclk);
    meas(4000, 1'b0, 4);
    `CHK(hi, 0)
    `CHK(out_word0, 16'hFFEF)
    $display("test duty change done");
    wreg(OFF_MODE, 32'h0000_0000);
    for (int c = 0; c < 4; c++)
    begin
      wreg(8'(OFF_FREQ0 + 4 * c), 32'h0000_FFFF);
      wreg(8'(OFF_DUTY0 + 4 * c), {16'h0000, DUTY_FULL});
    end
    wreg(OFF_CMD, 32'h0000_000F);
    repeat (4) @(posedge mclk);
    `CHK(out_word0, 16'hFFFF)
    `CHK(out_word1, 16'h00B5)
    rchk(OFF_ACT_LO, 32'h0000_0101);
    rchk(OFF_ACT_HI, 32'h0000_0101);
    meas(4000, 1'b1, 5);
    `CHK(hi, 4000)
    wreg(OFF_CMD, 32'h0000_0040);
    rchk(OFF_ACT_HI, 32'h0000_0100);
    repeat (2) @(posedge mclk);
    `CHK(out_word1, 16'h00A5)
    wreg(OFF_CMD, 32'h0000_0022);
    rchk(OFF_ACT_LO, 32'h0000_0001);
    $display("test four channels done");
    run_mode <= 1'b1;
    repeat (8) @(posedge mclk);
    rchk(OFF_ACT_LO, 32'h0000_0000);
    rchk(OFF_ACT_HI, 32'h0000_0000);
    `CHK(out_word1, 16'h00A5)
    wreg(OFF_CMD, 32'h0000_0001);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK(out_word0, 16'h0000)
    `CHK(irq, 1'b0)
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    rchk(OFF_ACT_LO, 32'h0000_0000);
    rchk(OFF_OUT0, 32'h0000_0000);
    $display("test run edge and reset done");
    close_out();
  end
endmodule
`default_nettype wire
